// ---- hw/wbc_pkg.sv ----
// constants for the wake and bus configuration register group
`default_nettype none
package wbc_pkg;
    // register byte offsets
    localparam logic [7:0] WBC_ADR_EEP_CMD = 8'h50;
    localparam logic [7:0] WBC_ADR_FUNC = 8'h52;
    localparam logic [7:0] WBC_ADR_BUS = 8'h53;
    localparam logic [7:0] WBC_ADR_WAKE = 8'h54;
    localparam logic [7:0] WBC_ADR_IRQ_STAT = 8'h58;
    localparam logic [7:0] WBC_ADR_IRQ_CLR = 8'h59;
    localparam logic [7:0] WBC_ADR_IRQ_EN = 8'h5a;
    // eeprom command register fields
    localparam int WBC_EEP_MODE_HI = 7;
    localparam int WBC_EEP_MODE_LO = 6;
    // function_enable_config fields
    localparam int WBC_FEC_PWE = 3;
    localparam int WBC_FEC_IOM = 2;
    localparam int WBC_FEC_PDE = 1;
    localparam int WBC_FEC_PMC = 0;
    // bus_platform_status fields
    localparam int WBC_BPS_AUX = 4;
    localparam int WBC_BPS_WID = 3;
    localparam logic [2:0] WBC_CLK_33 = 3'h0;
    localparam logic [2:0] WBC_CLK_66 = 3'h1;
    // wake_and_bus_options fields
    localparam int WBC_WBO_GSEL = 7;
    localparam int WBC_WBO_PAT = 5;
    localparam int WBC_WBO_LNK = 4;
    localparam int WBC_WBO_CB = 3;
    localparam int WBC_WBO_CR = 2;
    localparam int WBC_WBO_FR = 1;
    localparam int WBC_WBO_FB = 0;
    // interrupt status fields
    localparam int WBC_IRQ_PAT = 0;
    localparam int WBC_IRQ_LNK = 1;
    localparam int WBC_IRQ_N = 2;
    // capability list values
    localparam logic [7:0] WBC_CAP_PTR_PM = 8'hdc;
    localparam logic [7:0] WBC_PM_CAP_ID = 8'h01;
    localparam logic [7:0] WBC_PM_NEXT_VPD = 8'he4;
    localparam logic [6:0] WBC_VPD_FIRST = 7'h40;
    localparam logic [6:0] WBC_VPD_LAST = 7'h7f;
    // wake pattern shape
    localparam logic [7:0] WBC_SYNC_BYTE = 8'hff;
    localparam logic [2:0] WBC_SYNC_LEN = 3'h6;
    localparam logic [2:0] WBC_ID_LAST = 3'h5;
    localparam logic [4:0] WBC_REP_LAST = 5'hf;
    localparam logic [3:0] WBC_HDR_LEN = 4'he;
    // strap settle time after reset release
    localparam logic [1:0] WBC_SETTLE = 2'h3;
endpackage : wbc_pkg
`default_nettype wire

// ---- hw/wbc_regs.sv ----
// wake and bus configuration registers with wake pattern detector
// What this block does
// R01 - product-data enable exposes eeprom words 40h-7Fh
// R02 - pm enable drives status bit and pointers
// R03 - pm next pointer follows product-data enable
// R04 - aux power bit captured once per reset
// R05 - grant select adds one clock before frame
// R06 - pattern wake plus power wake asserts wake
// R07 - only own-ID or multicast frames are examined
// R08 - six FFh then sixteen ID repeats
// R09 - wake frame needs full header and good crc
// R10 - link restore wake in suitable power state
// R11 - cardbus bit enables cardbus functions
// R12 - function register enable gates four registers
// R13 - fast back-to-back bit reports enable
// R14 - pm enable writable only in config mode
// R15 - slot width and clock code reported
// R16 - clock-run enable switches clock-run support
`default_nettype none
module wbc_regs
    import wbc_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    // bus arbitration
    input wire logic i_bus_req,
    input wire logic i_gnt_n,
    output logic o_frame_n,
    // board straps and platform status
    input wire logic i_aux_power,
    input wire logic i_slot_width,
    input wire logic [2:0] i_bus_clock_rate_code,
    input wire logic i_grant_frame_delay_sel,
    input wire logic i_pc_card_bus_enable,
    input wire logic i_clock_run_enable,
    input wire logic i_function_event_regs_enable,
    input wire logic i_fast_b2b_enable,
    input wire logic i_io_space_mapped,
    // receive byte stream
    input wire logic i_rx_valid,
    input wire logic i_rx_sof,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_eof,
    input wire logic i_rx_crc_ok,
    input wire logic [47:0] i_station_id,
    // link and power state
    input wire logic i_link_up,
    input wire logic i_pm_state_ok,
    // capability list view
    output logic o_new_cap,
    output logic [7:0] o_cap_ptr,
    output logic [7:0] o_pm_cap_id,
    output logic [7:0] o_pm_next_ptr,
    output logic o_pm_regs_valid,
    output logic o_vpd_enable,
    output logic [6:0] o_vpd_first,
    output logic [6:0] o_vpd_last,
    // function enables
    output logic o_clock_run_active,
    output logic o_cardbus_active,
    output logic o_func_regs_active,
    output logic o_fast_b2b,
    // wake and interrupt
    output logic o_wake_request_out,
    output logic o_irq
);

    // pin synchronisers: stage one feeds stage two only
    localparam int NPIN = 15;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    assign pin_raw = {i_gnt_n, i_link_up, i_pm_state_ok, i_aux_power,
        i_slot_width, i_bus_clock_rate_code, i_grant_frame_delay_sel,
        i_pc_card_bus_enable, i_clock_run_enable,
        i_function_event_regs_enable, i_fast_b2b_enable,
        i_io_space_mapped, 1'b0};

    always_ff @(posedge i_core_clk) begin
        // grant pin idles high, so reset it there to avoid a false grant
        if (!i_rst_b) begin
            pin_s1 <= {1'b1, {(NPIN-1){1'b0}}};
            pin_s2 <= {1'b1, {(NPIN-1){1'b0}}};
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    logic gnt_n_s;
    logic link_s;
    logic pm_ok_s;
    assign gnt_n_s = pin_s2[14];
    assign link_s = pin_s2[13];
    assign pm_ok_s = pin_s2[12];

    // strap capture once per reset, after the synchronisers settle
    logic [1:0] settle;
    logic captured;
    logic [7:0] bus_stat;
    logic [7:0] opt_ro;
    logic io_map;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            settle <= 2'h0;
            captured <= 1'b0;
            bus_stat <= 8'h00;
            opt_ro <= 8'h00;
            io_map <= 1'b0;
        end else if (!captured) begin
            settle <= settle + 2'h1;
            if (settle == WBC_SETTLE) begin
                captured <= 1'b1;
                bus_stat <= {3'h0, pin_s2[11:7]}; // R04 R15
                opt_ro <= {pin_s2[6], 3'h0, pin_s2[5:2]}; // R05 R11 R13 R16
                io_map <= pin_s2[1];
            end
        end
    end

    // software registers
    logic [1:0] eep_mode;
    logic pde;
    logic pmc;
    logic pwe;
    logic pat_en;
    logic lnk_en;
    logic [WBC_IRQ_N-1:0] irq_en;
    logic wr_func;
    assign wr_func = i_wr && (i_addr == WBC_ADR_FUNC);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            eep_mode <= 2'h0;
            pde <= 1'b0;
            pmc <= 1'b0;
            pwe <= 1'b0;
            pat_en <= 1'b0;
            lnk_en <= 1'b0;
            irq_en <= '0;
        end else if (i_wr) begin
            if (i_addr == WBC_ADR_EEP_CMD) begin
                eep_mode <= i_wr_data[WBC_EEP_MODE_HI:WBC_EEP_MODE_LO];
            end
            if (wr_func) begin
                pde <= i_wr_data[WBC_FEC_PDE];
                pwe <= i_wr_data[WBC_FEC_PWE];
                // locked unless eeprom is in config-write mode
                if (eep_mode == 2'h3) begin
                    pmc <= i_wr_data[WBC_FEC_PMC]; // R14
                end
            end
            if (i_addr == WBC_ADR_WAKE) begin
                pat_en <= i_wr_data[WBC_WBO_PAT];
                lnk_en <= i_wr_data[WBC_WBO_LNK];
            end
            if (i_addr == WBC_ADR_IRQ_EN) begin
                irq_en <= i_wr_data[WBC_IRQ_N-1:0];
            end
        end
    end

    // capability list and function enables
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_new_cap <= 1'b0;
            o_cap_ptr <= 8'h00;
            o_pm_cap_id <= 8'h00;
            o_pm_next_ptr <= 8'h00;
            o_pm_regs_valid <= 1'b0;
            o_vpd_enable <= 1'b0;
            o_vpd_first <= 7'h00;
            o_vpd_last <= 7'h00;
            o_clock_run_active <= 1'b0;
            o_cardbus_active <= 1'b0;
            o_func_regs_active <= 1'b0;
            o_fast_b2b <= 1'b0;
        end else begin
            o_new_cap <= pmc; // R02
            o_cap_ptr <= pmc ? WBC_CAP_PTR_PM : 8'h00; // R02
            o_pm_cap_id <= pmc ? WBC_PM_CAP_ID : 8'h00; // R02
            o_pm_regs_valid <= pmc; // R02
            o_pm_next_ptr <= (pmc && pde) ? WBC_PM_NEXT_VPD : 8'h00; // R03
            o_vpd_enable <= pde; // R01
            o_vpd_first <= pde ? WBC_VPD_FIRST : 7'h00; // R01
            o_vpd_last <= pde ? WBC_VPD_LAST : 7'h00; // R01
            o_clock_run_active <= opt_ro[WBC_WBO_CR]; // R16
            o_cardbus_active <= opt_ro[WBC_WBO_CB]; // R11
            // function registers only exist on a cardbus part
            o_func_regs_active <= opt_ro[WBC_WBO_CB] && opt_ro[WBC_WBO_FR]; // R12
            o_fast_b2b <= opt_ro[WBC_WBO_FB]; // R13
        end
    end

    // frame start after grant, optionally one clock later
    logic gnt_act;
    logic gnt_d;
    assign gnt_act = i_bus_req && !gnt_n_s;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            gnt_d <= 1'b0;
            o_frame_n <= 1'b1;
        end else begin
            gnt_d <= gnt_act;
            o_frame_n <= !(i_bus_req && (!o_frame_n ||
                (gnt_act && (!opt_ro[WBC_WBO_GSEL] || gnt_d)))); // R05
        end
    end

    // station ID byte k, first on the wire is the top byte
    function automatic logic [7:0] id_byte(input logic [47:0] id,
            input logic [2:0] k);
        logic [47:0] sh;
        sh = id << (6'(k) * 6'd8);
        id_byte = sh[47:40];
    endfunction : id_byte

    // receive frame tracking and wake pattern matcher
    logic [3:0] pos;
    logic dest_own;
    logic dest_mc;
    logic [2:0] ff_cnt;
    logic [2:0] col;
    logic [4:0] rep;
    logic found;
    logic [3:0] pos_b;
    logic [2:0] col_b;
    logic [4:0] rep_b;
    logic [2:0] ff_b;
    logic hit;
    logic in_match;

    always_comb begin
        pos_b = i_rx_sof ? 4'h0 : pos;
        col_b = i_rx_sof ? 3'h0 : col;
        rep_b = i_rx_sof ? 5'h0 : rep;
        ff_b = i_rx_sof ? 3'h0 : ff_cnt;
        hit = (i_rx_data == id_byte(i_station_id, col_b));
        in_match = (col_b != 3'h0) || (rep_b != 5'h0);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            pos <= 4'h0;
            dest_own <= 1'b0;
            dest_mc <= 1'b0;
            ff_cnt <= 3'h0;
            col <= 3'h0;
            rep <= 5'h0;
            found <= 1'b0;
        end else if (i_rx_valid) begin
            if (pos_b != 4'hf) begin
                pos <= pos_b + 4'h1;
            end
            // destination must be own ID or any multicast
            if (pos_b == 4'h0) begin
                dest_own <= (i_rx_data == id_byte(i_station_id, 3'h0)); // R07
                dest_mc <= i_rx_data[0]; // R07
            end else if (pos_b < 4'h6) begin
                dest_own <= dest_own &&
                    (i_rx_data == id_byte(i_station_id, pos_b[2:0])); // R07
            end
            if (i_rx_sof) begin
                found <= 1'b0;
            end
            if (i_rx_data == WBC_SYNC_BYTE) begin
                ff_cnt <= (ff_b == WBC_SYNC_LEN) ? ff_b : ff_b + 3'h1;
            end else begin
                ff_cnt <= 3'h0;
            end
            // sync run must lead straight into the repeats
            if (hit && (in_match || ff_b == WBC_SYNC_LEN)) begin // R08
                col <= (col_b == WBC_ID_LAST) ? 3'h0 : col_b + 3'h1;
                if (col_b == WBC_ID_LAST) begin
                    rep <= rep_b + 5'h1;
                    if (rep_b == WBC_REP_LAST) begin
                        found <= 1'b1; // R08
                        rep <= 5'h0;
                    end
                end
            end else begin
                col <= 3'h0;
                rep <= 5'h0;
            end
        end
    end

    // wake events, pattern judged at end of frame, link on its rising edge
    logic link_d;
    logic ev_pat;
    logic ev_lnk;
    always_comb begin
        ev_pat = i_rx_eof && i_rx_crc_ok && (pos >= WBC_HDR_LEN) // R09
            && (dest_own || dest_mc) && found // R07 R08
            && pat_en && pwe; // R06
        ev_lnk = link_s && !link_d && lnk_en && pwe && pm_ok_s; // R10
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            link_d <= 1'b0;
        end else begin
            link_d <= link_s;
        end
    end

    // sticky status, a new event wins over a clear
    logic [WBC_IRQ_N-1:0] irq_stat;
    logic [WBC_IRQ_N-1:0] next_irq_stat;
    logic [WBC_IRQ_N-1:0] clr;
    always_comb begin
        clr = '0;
        if (i_wr && i_addr == WBC_ADR_IRQ_CLR) begin
            clr = i_wr_data[WBC_IRQ_N-1:0];
        end
        next_irq_stat = (irq_stat & ~clr) | {ev_lnk, ev_pat};
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            irq_stat <= '0;
            o_irq <= 1'b0;
            o_wake_request_out <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            o_irq <= |(next_irq_stat & irq_en);
            // wake stays up until software clears the cause
            o_wake_request_out <= |next_irq_stat; // R06 R10
        end
    end

    // register read, data stands one cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rd_data <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                WBC_ADR_EEP_CMD: o_rd_data <= {eep_mode, 6'h00};
                WBC_ADR_FUNC: o_rd_data <= {4'h0, pwe, io_map, pde, pmc};
                WBC_ADR_BUS: o_rd_data <= bus_stat; // R04 R15
                WBC_ADR_WAKE: o_rd_data <= opt_ro |
                    {2'h0, pat_en, lnk_en, 4'h0};
                WBC_ADR_IRQ_STAT: o_rd_data <= 8'(irq_stat);
                WBC_ADR_IRQ_EN: o_rd_data <= 8'(irq_en);
                default: o_rd_data <= 8'h00;
            endcase
        end else begin
            o_rd_data <= 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_func_wr_locked;
        wr_func && eep_mode != 2'h3;
    endsequence

    sequence s_pat_event;
        ev_pat;
    endsequence

    AST_PMC_LOCKED: assert property (s_func_wr_locked |=> $stable(pmc)) // R14
        else $error("pm enable changed while locked");

    AST_CAP_PTR: assert property (pmc |=> o_cap_ptr == WBC_CAP_PTR_PM && o_new_cap) // R02
        else $error("capability pointer wrong with pm enabled");

    AST_CAP_OFF: assert property (!pmc |=> o_cap_ptr == 8'h00 && o_pm_cap_id == 8'h00) // R02
        else $error("capability fields nonzero with pm disabled");

    AST_NEXT_PTR: assert property ((pmc && !pde) |=> o_pm_next_ptr == 8'h00) // R03
        else $error("next pointer set without product data");

    AST_VPD: assert property (pde |=> o_vpd_last == WBC_VPD_LAST) // R01
        else $error("product data window wrong");

    AST_AUX_HELD: assert property (captured |=> $stable(bus_stat)) // R04
        else $error("platform status moved after capture");

    AST_FRAME_NODLY: assert property ((!opt_ro[WBC_WBO_GSEL] && o_frame_n
            && gnt_act) |=> !o_frame_n) // R05
        else $error("frame late without grant delay");

    AST_FRAME_DLY: assert property ((opt_ro[WBC_WBO_GSEL] && o_frame_n
            && gnt_act && !gnt_d) |=> o_frame_n) // R05
        else $error("frame early with grant delay");

    AST_PAT_WAKE: assert property (s_pat_event |=> o_wake_request_out
            && irq_stat[WBC_IRQ_PAT]) // R06
        else $error("pattern frame did not raise wake");

    AST_NO_WAKE: assert property ((!pwe && irq_stat == '0 && !ev_lnk && !ev_pat)
            |=> !o_wake_request_out) // R10
        else $error("wake raised without cause");

    AST_CRC: assert property ((i_rx_eof && !i_rx_crc_ok) |-> !ev_pat) // R09
        else $error("bad frame accepted as wake");

    AST_FUNC_REGS: assert property (!opt_ro[WBC_WBO_CB] |=> !o_func_regs_active) // R12
        else $error("function registers active off cardbus");

endmodule : wbc_regs
`default_nettype wire

// ---- testbench/wbc_host_arb.sv ----
// host-side arbiter model that grants the bus after a chosen wait
`default_nettype none
module wbc_host_arb (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // request from the device and wait length
    input wire logic i_req,
    input wire logic [1:0] i_wait,
    // grant pin
    output logic o_gnt_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    // grant withdrawn as soon as the request drops, as a real arbiter may
    always @(posedge i_core_clk) begin
        if (!i_rst_b || !i_req) begin
            cnt <= 2'h0;
            o_gnt_n <= 1'b1;
        end else if (cnt == i_wait) begin
            o_gnt_n <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule : wbc_host_arb
`default_nettype wire

// ---- testbench/test_wbc_regs.sv ----
// self-checking bench for the wake and bus configuration registers
`default_nettype none
module test_wbc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import wbc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, i_rx_data = 8'h00, o_rd_data, rv;
    logic i_wr = 1'b0, i_rd = 1'b0, i_bus_req = 1'b0, i_gnt_n, o_frame_n;
    logic i_rx_valid = 1'b0, i_rx_sof = 1'b0, i_rx_eof = 1'b0, i_rx_crc_ok = 1'b0;
    logic i_link_up = 1'b0, i_pm_state_ok = 1'b0;
    logic [47:0] i_station_id = 48'h0;
    wire logic i_aux_power, i_slot_width, i_grant_frame_delay_sel, i_pc_card_bus_enable;
    wire logic i_clock_run_enable, i_function_event_regs_enable, i_fast_b2b_enable;
    wire logic i_io_space_mapped;
    wire logic [2:0] i_bus_clock_rate_code;
    logic o_new_cap, o_pm_regs_valid, o_vpd_enable, o_clock_run_active, o_cardbus_active;
    logic o_func_regs_active, o_fast_b2b, o_wake_request_out, o_irq;
    logic [7:0] o_cap_ptr, o_pm_cap_id, o_pm_next_ptr;
    logic [6:0] o_vpd_first, o_vpd_last;
    logic [10:0] st = 11'h0; // aux wid code[2:0] gsel cb cr fr fb iom
    logic [31:0] seed = 32'h6;
    logic [1:0] arb_wait = 2'h0;
    logic [7:0] q[$];
    logic [47:0] dst;
    int n_mismatch = 0, checks = 0, exp_st = 0, en = 0, n;

    assign {i_aux_power, i_slot_width, i_bus_clock_rate_code, i_grant_frame_delay_sel,
            i_pc_card_bus_enable, i_clock_run_enable, i_function_event_regs_enable,
            i_fast_b2b_enable, i_io_space_mapped} = st;

    wbc_regs wbc_regs_i (.i_core_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr, .i_rd,
        .o_rd_data, .i_bus_req, .i_gnt_n, .o_frame_n, .i_aux_power, .i_slot_width,
        .i_bus_clock_rate_code, .i_grant_frame_delay_sel, .i_pc_card_bus_enable,
        .i_clock_run_enable, .i_function_event_regs_enable, .i_fast_b2b_enable,
        .i_io_space_mapped, .i_rx_valid, .i_rx_sof, .i_rx_data, .i_rx_eof, .i_rx_crc_ok,
        .i_station_id, .i_link_up, .i_pm_state_ok, .o_new_cap, .o_cap_ptr, .o_pm_cap_id,
        .o_pm_next_ptr, .o_pm_regs_valid, .o_vpd_enable, .o_vpd_first, .o_vpd_last,
        .o_clock_run_active, .o_cardbus_active, .o_func_regs_active, .o_fast_b2b,
        .o_wake_request_out, .o_irq);

    wbc_host_arb wbc_host_arb_i (.i_core_clk, .i_rst_b, .i_req(i_bus_req),
        .i_wait(arb_wait), .o_gnt_n(i_gnt_n));

    always #2 i_core_clk = ~i_core_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 rv = o_rd_data;
    endtask : rd

    // straps are held through reset and well past the capture point
    task automatic rst();
        @(posedge i_core_clk);
        i_rst_b <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (10) @(posedge i_core_clk);
    endtask : rst

    // frame model: dest, source, misc, sync run, id repeats, crc bytes
    task automatic mk(input int nsy, input int nrp);
        q.delete();
        for (int i = 0; i < 6; i++) q.push_back(dst[47-8*i -: 8]);
        for (int i = 0; i < 9; i++) q.push_back(8'(xs()) & 8'h7f);
        for (int i = 0; i < nsy; i++) q.push_back(8'hff);
        for (int i = 0; i < 6 * nrp; i++) q.push_back(i_station_id[47-8*(i%6) -: 8]);
        for (int i = 0; i < 4; i++) q.push_back(8'(xs()) & 8'h7f);
    endtask : mk

    function automatic bit wake_frame(input bit ok);
        bit hit;
        if (!ok || q.size() < 14) return 0;
        if ({q[0], q[1], q[2], q[3], q[4], q[5]} != i_station_id && !q[0][0]) return 0;
        for (int i = 0; i + 102 <= q.size(); i++) begin
            hit = 1;
            for (int j = 0; j < 102; j++)
                if (q[i+j] !== (j < 6 ? 8'hff : i_station_id[47-8*((j-6)%6) -: 8])) hit = 0;
            if (hit) return 1;
        end
        return 0;
    endfunction : wake_frame

    task automatic send(input bit ok);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge i_core_clk);
            i_rx_valid <= 1'b1;
            i_rx_sof <= (i == 0);
            i_rx_data <= q[i];
        end
        @(posedge i_core_clk);
        i_rx_valid <= 1'b0;
        i_rx_sof <= 1'b0;
        i_rx_eof <= 1'b1;
        i_rx_crc_ok <= ok;
        @(posedge i_core_clk);
        i_rx_eof <= 1'b0;
        i_rx_crc_ok <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        if (wake_frame(ok)) exp_st = exp_st | 1;
    endtask : send

    task automatic stat();
        rd(WBC_ADR_IRQ_STAT);
        chk(rv, 8'(exp_st));
        chk(8'(o_wake_request_out), 8'(exp_st != 0));
        chk(8'(o_irq), 8'((exp_st & en) != 0));
    endtask : stat

    task automatic complete_run();
        $display("%0d comparisons, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run

    // the whole run needs some 1100 cycles; this cuts a hang at 25000
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        st = 11'(xs()) & 11'h63f;
        i_station_id = 48'({xs(), xs()}) & 48'hfeff_ffff_ffff;
        rst();
        rd(WBC_ADR_BUS);
        chk(rv, {3'h0, st[10:6]});
        st <= st ^ 11'h400;
        wr(WBC_ADR_BUS, 8'hff);
        repeat (4) @(posedge i_core_clk);
        rd(WBC_ADR_BUS);
        chk(rv, {3'h0, ~st[10], st[9:6]});
        rd(WBC_ADR_WAKE);
        chk(rv, {st[5], 3'h0, st[4:1]});
        chk(8'(o_cardbus_active), 8'(st[4]));
        chk(8'(o_clock_run_active), 8'(st[3]));
        chk(8'(o_fast_b2b), 8'(st[1]));
        chk(8'(o_func_regs_active), 8'(st[4] & st[2]));
        rd(8'h57);
        chk(rv, 8'h00);
        $display("straps and status test done");
        wr(WBC_ADR_FUNC, 8'h0f);
        rd(WBC_ADR_FUNC);
        chk(rv, {4'h0, 1'b1, st[0], 2'h2});
        wr(WBC_ADR_EEP_CMD, 8'hc0);
        wr(WBC_ADR_FUNC, 8'h0b);
        repeat (2) @(posedge i_core_clk);
        rd(WBC_ADR_FUNC);
        chk(rv, {4'h0, 1'b1, st[0], 2'h3});
        chk({o_new_cap, o_pm_regs_valid, o_vpd_enable, 5'h0}, 8'he0);
        chk(o_cap_ptr, WBC_CAP_PTR_PM);
        chk(o_pm_cap_id, WBC_PM_CAP_ID);
        chk(o_pm_next_ptr, WBC_PM_NEXT_VPD);
        chk({1'b0, o_vpd_first}, 8'h40);
        chk({1'b0, o_vpd_last}, 8'h7f);
        wr(WBC_ADR_FUNC, 8'h09);
        repeat (2) @(posedge i_core_clk);
        chk(o_pm_next_ptr, 8'h00);
        chk({o_vpd_enable, o_vpd_first}, 8'h00);
        wr(WBC_ADR_FUNC, 8'h08);
        repeat (2) @(posedge i_core_clk);
        chk({o_new_cap, o_pm_regs_valid, 6'h0}, 8'h00);
        chk(o_cap_ptr | o_pm_cap_id, 8'h00);
        $display("capability test done");
        wr(WBC_ADR_WAKE, 8'h20);
        wr(WBC_ADR_IRQ_EN, 8'h01);
        en = 1;
        for (int k = 0; k < 7; k++) begin
            wr(WBC_ADR_IRQ_CLR, 8'h03);
            exp_st = 0;
            dst = k == 4 ? i_station_id ^ 48'h0200_0000_0000 : k == 5 ? 48'hffff_ffff_ffff
                : k == 6 ? 48'h0100_0000_0001 : i_station_id;
            mk(k == 3 ? 5 : 6, k == 2 ? 15 : 16);
            send(k != 1);
            stat();
        end
        $display("pattern wake test done");
        wr(WBC_ADR_IRQ_CLR, 8'h03);
        exp_st = 0;
        i_pm_state_ok <= 1'b1;
        i_link_up <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        stat();
        i_link_up <= 1'b0;
        wr(WBC_ADR_WAKE, 8'h30);
        wr(WBC_ADR_IRQ_EN, 8'h00);
        en = 0;
        repeat (8) @(posedge i_core_clk);
        i_link_up <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        exp_st = 2;
        stat();
        wr(WBC_ADR_IRQ_EN, 8'h02);
        en = 2;
        stat();
        wr(WBC_ADR_IRQ_CLR, 8'h02);
        exp_st = 0;
        stat();
        // a link restore outside a suitable power state must not wake
        i_link_up <= 1'b0;
        i_pm_state_ok <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        i_link_up <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        stat();
        $display("link wake test done");
        // grant-to-frame spacing for both strap values and random arbiter waits
        for (int s = 0; s < 2; s++) begin
            st[5] <= s[0];
            rst();
            rd(WBC_ADR_BUS);
            chk(rv, {3'h0, st[10:6]});
            arb_wait <= 2'(xs());
            i_bus_req <= 1'b1;
            n = 0;
            while (i_gnt_n !== 1'b0 && n < 20) begin
                @(posedge i_core_clk);
                #1 n++;
            end
            n = 0;
            while (o_frame_n !== 1'b0 && n < 20) begin
                @(posedge i_core_clk);
                #1 n++;
            end
            chk(8'(n), 8'(3 + s));
            @(posedge i_core_clk);
            i_bus_req <= 1'b0;
            repeat (2) @(posedge i_core_clk);
            #1 chk(8'(o_frame_n), 8'h01);
        end
        $display("arbitration test done");
        complete_run();
    end
endmodule : test_wbc_regs
`default_nettype wire
